//--- rtl/twi_pkg.sv
// Constants and types for the two-wire serial master/slave port
// Functional notes
// - Serial rate up to one twentieth of system clock, master or slave.
// - Transfer opens with START, then seven address bits and direction bit.
// - Direction bit one means read from slave, zero means write.
// - Receiver acks with SDA low during SCL high; high means not-ack.
// - Master sends START, address, then write bytes, awaiting ack each.
// - On read the slave sends bytes and awaits master ack each.
// - Master ends every transfer with STOP, freeing the bus.
// - Master starts only on free bus: after STOP or free timeout.
// - Master sampling low while sending high loses; becomes slave receiver in address byte, else ignores bus.
// - SCL and SDA are open-drain only; released lines float high.
// - Slave may stretch SCL low; master waits for SCL really high.
// - SCL low beyond 25 ms is timeout; reset link within 10 ms.
// - With timeout enabled, timer reloads while SCL high, counts when low.
// - Bus free after both lines high over ten source periods.
// - Pending master START goes out as soon as free timeout expires.
// - Free timeout needs the selected overflow source, even slave-only.
// - Interrupt per byte; when sending it follows the ack cycle.
// - When receiving, interrupt precedes ack; software supplies ack value.
// - Interrupt on master START generated and on slave STOP detected.
// - One byte register holds outgoing and incoming bytes; shifting autonomous.
// - SCL clock pulses driven only as master; slave follows SCL.
// - Source select 00,01,10,11: timer0, timer1, timer2 high, timer2 low.
// - One overflow sets minimum SCL low and high; bit rate overflow/3.
// - Slave inhibited: lines watched, addresses not-acked, no slave interrupts; the port masks only the address-byte and STOP-detect interrupts.
// - Free timeout acts as STOP detected: interrupt and stop flag.
package twi_pkg;

    // Overflow source codes
    localparam logic [1:0] SRC_T0 = 2'h0;
    localparam logic [1:0] SRC_T1 = 2'h1;
    localparam logic [1:0] SRC_T2H = 2'h2;
    localparam logic [1:0] SRC_T2L = 2'h3;

    // SCL phase lengths in overflow periods, minus one
    localparam int TCNT_W = 2;
    localparam logic [TCNT_W-1:0] LOW_END = 2'h0;
    localparam logic [TCNT_W-1:0] HIGH_END = 2'h1;

    // Free timeout: more than ten source periods
    localparam logic [3:0] FREE_TICKS = 4'ha;

    // Bit counter marks
    localparam logic [3:0] DIR_CNT = 4'h7;
    localparam logic [3:0] ACK_CNT = 4'h8;
    localparam logic [3:0] DONE_CNT = 4'h9;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_XFER,
        ST_IGNORE,
        ST_STOP
    } state_t;

endpackage

//--- rtl/twi_serial_port.sv
// Two-wire serial master/slave port with byte shifter and bus monitor
`timescale 1ns/1ps
module twi_serial_port
    import twi_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Configuration
    input wire logic enable_i,
    input wire logic slave_event_inhibit_i,
    input wire logic scl_low_timeout_enable_i,
    input wire logic bus_free_timeout_enable_i,
    input wire logic [1:0] bit_clock_source_select_i,
    // Timer overflow pulses
    input wire logic tick_t0_i,
    input wire logic tick_t1_i,
    input wire logic tick_t2h_i,
    input wire logic tick_t2l_i,
    // Software requests
    input wire logic start_req_i,
    input wire logic stop_req_i,
    input wire logic irq_clear_i,
    input wire logic ack_out_i,
    input wire logic data_wr_i,
    input wire logic [7:0] data_i,
    // Status
    output logic irq_o,
    output logic master_o,
    output logic tx_mode_o,
    output logic start_flag_o,
    output logic stop_flag_o,
    output logic ack_rx_o,
    output logic arb_lost_o,
    output logic busy_o,
    output logic [7:0] data_o,
    output logic timer_reload_o,
    // Bus pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);

    state_t state_r;
    logic [2:0] sync_r [2];
    logic lvl_r [2];
    logic [1:0] pin_c;
    logic scl_f, sda_f, scl_rise, scl_fall, sda_rise, sda_fall;
    logic start_det, stop_det, tick, lo_done, hi_done, free_done, tx_msb;
    logic scl_low_r, sda_low_r, zero_r, irq_r, master_r, tx_mode_r;
    logic start_pend_r, stop_flag_r, ack_rx_r, arb_lost_r, busy_r;
    logic addr_r, dir_r, inh_r, reload_r;
    logic [TCNT_W-1:0] tcnt_r;
    logic [3:0] free_cnt_r, cnt_r;
    logic [7:0] shreg_r;

    // Line synchronisers, three stages each
    // filter latency
    assign pin_c = {sda_i, scl_i};
    for (genvar g = 0; g < 2; g++) begin : g_sync
        always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                sync_r[g] <= 3'h7;
                lvl_r[g] <= 1'b1;
            end else begin
                sync_r[g] <= {sync_r[g][1:0], pin_c[g]};
                if (sync_r[g][2] == sync_r[g][1]) begin
                    lvl_r[g] <= sync_r[g][2];
                end
            end
        end
    end

    // Filtered levels and their edges
    assign scl_f = lvl_r[0];
    assign sda_f = lvl_r[1];
    assign scl_rise = (sync_r[0][2:1] == 2'h3) && !scl_f;
    assign scl_fall = (sync_r[0][2:1] == 2'h0) && scl_f;
    assign sda_rise = (sync_r[1][2:1] == 2'h3) && !sda_f;
    assign sda_fall = (sync_r[1][2:1] == 2'h0) && sda_f;
    assign start_det = sda_fall && scl_f && !scl_fall;
    assign stop_det = sda_rise && scl_f && !scl_fall;

    // Overflow source selection
    // source mapping
    always_comb begin
        tick = 1'b0;
        unique case (bit_clock_source_select_i)
            SRC_T0: tick = tick_t0_i;
            SRC_T1: tick = tick_t1_i;
            SRC_T2H: tick = tick_t2h_i;
            SRC_T2L: tick = tick_t2l_i;
        endcase
    end

    // Phase ends of the master clock
    assign lo_done = scl_low_r && tick && (tcnt_r == LOW_END);
    assign hi_done = master_r && !scl_low_r && scl_f && tick &&
                     (tcnt_r == HIGH_END);
    assign tx_msb = data_wr_i ? data_i[7] : shreg_r[7];

    // SCL driver: master timing and interrupt hold
    // one tick low, two high
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_low_r <= 1'b0;
            tcnt_r <= '0;
        end else if (!enable_i || state_r == ST_IDLE ||
                     state_r == ST_IGNORE) begin
            scl_low_r <= 1'b0;
            tcnt_r <= '0;
        end else if (irq_r) begin
            scl_low_r <= 1'b1;
            tcnt_r <= '0;
        end else if (!master_r) begin
            scl_low_r <= 1'b0;
            tcnt_r <= '0;
        end else if (scl_low_r) begin
            if (lo_done) begin
                scl_low_r <= 1'b0;
                tcnt_r <= '0;
            end else if (tick) begin
                tcnt_r <= tcnt_r + 2'h1;
            end
        end else if (!scl_f) begin
            tcnt_r <= '0;
        end else if (hi_done) begin
            tcnt_r <= '0;
            scl_low_r <= (state_r != ST_STOP);
        end else if (tick) begin
            tcnt_r <= tcnt_r + 2'h1;
        end
    end

    // Bus free counter
    // counts source periods
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            free_cnt_r <= '0;
        end else if (!enable_i || !(scl_f && sda_f)) begin
            free_cnt_r <= '0;
        end else if (tick && free_cnt_r != FREE_TICKS) begin
            free_cnt_r <= free_cnt_r + 4'h1;
        end
    end
    assign free_done = enable_i && bus_free_timeout_enable_i && busy_r &&
                       scl_f && sda_f && tick && (free_cnt_r == FREE_TICKS);

    // External timeout timer reload
    // reload while SCL high
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reload_r <= 1'b0;
            zero_r <= 1'b0;
        end else begin
            reload_r <= enable_i && scl_low_timeout_enable_i && scl_f;
            zero_r <= 1'b0;
        end
    end

    // Transfer sequencer, shifter and flags
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= ST_IDLE;
            sda_low_r <= 1'b0;
            irq_r <= 1'b0;
            master_r <= 1'b0;
            tx_mode_r <= 1'b0;
            start_pend_r <= 1'b0;
            stop_flag_r <= 1'b0;
            ack_rx_r <= 1'b0;
            arb_lost_r <= 1'b0;
            busy_r <= 1'b0;
            addr_r <= 1'b0;
            dir_r <= 1'b0;
            inh_r <= 1'b0;
            cnt_r <= '0;
            shreg_r <= '0;
        end else if (!enable_i) begin
            state_r <= ST_IDLE;
            sda_low_r <= 1'b0;
            irq_r <= 1'b0;
            master_r <= 1'b0;
            start_pend_r <= 1'b0;
            stop_flag_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            if (data_wr_i && (irq_r || state_r != ST_XFER)) begin
                shreg_r <= data_i;
            end
            if (irq_clear_i && irq_r) begin
                irq_r <= 1'b0;
                if (!master_r) begin
                    stop_flag_r <= 1'b0;
                end
                if (state_r == ST_XFER) begin
                    if (cnt_r == ACK_CNT) begin
                        sda_low_r <= ack_out_i;
                    end else if (master_r && stop_flag_r) begin
                        state_r <= ST_STOP;
                        sda_low_r <= 1'b1;
                    end else begin
                        sda_low_r <= tx_mode_r && !tx_msb;
                    end
                end
            end
            if (start_req_i) begin
                start_pend_r <= 1'b1;
            end
            if (stop_req_i) begin
                stop_flag_r <= 1'b1;
            end
            unique case (state_r)
                ST_IDLE: begin
                    if (start_pend_r && !busy_r && scl_f && sda_f &&
                        !start_det) begin
                        state_r <= ST_START;
                        master_r <= 1'b1;
                        sda_low_r <= 1'b1;
                        arb_lost_r <= 1'b0;
                    end
                end
                ST_START: begin
                    if (hi_done) begin
                        state_r <= ST_XFER;
                        irq_r <= 1'b1;
                        start_pend_r <= start_req_i; // New request wins
                        cnt_r <= '0;
                        tx_mode_r <= 1'b1;
                        addr_r <= 1'b1;
                    end
                end
                ST_XFER: begin
                    if (irq_r) begin
                        cnt_r <= cnt_r;
                    end else if (scl_rise) begin
                        if (cnt_r != DONE_CNT) begin
                            cnt_r <= cnt_r + 4'h1;
                        end
                        if (cnt_r == ACK_CNT) begin
                            ack_rx_r <= !sda_f;
                        end else if (cnt_r < ACK_CNT) begin
                            shreg_r <= {shreg_r[6:0], sda_f};
                            if (addr_r && cnt_r == DIR_CNT) begin
                                dir_r <= sda_f;
                            end
                            if (master_r && tx_mode_r && !sda_low_r &&
                                !sda_f) begin
                                master_r <= 1'b0;
                                arb_lost_r <= 1'b1;
                                tx_mode_r <= 1'b0;
                                if (!addr_r) begin
                                    state_r <= ST_IGNORE;
                                end
                            end
                        end
                    end else if (scl_fall) begin
                        if (cnt_r < ACK_CNT) begin
                            sda_low_r <= tx_mode_r && !shreg_r[7];
                        end else if (cnt_r == ACK_CNT) begin
                            if (tx_mode_r) begin
                                sda_low_r <= 1'b0;
                            end else if (addr_r && !master_r && inh_r) begin
                                sda_low_r <= 1'b0;
                            end else begin
                                irq_r <= 1'b1;
                            end
                        end else begin
                            cnt_r <= '0;
                            addr_r <= 1'b0;
                            if (tx_mode_r) begin
                                irq_r <= 1'b1;
                            end
                            if (addr_r && master_r) begin
                                tx_mode_r <= !dir_r;
                            end else if (addr_r && !ack_rx_r) begin
                                state_r <= ST_IGNORE;
                            end else if (addr_r) begin
                                tx_mode_r <= dir_r;
                            end
                            if (!tx_mode_r) begin
                                if (master_r && stop_flag_r) begin
                                    state_r <= ST_STOP;
                                    sda_low_r <= 1'b1;
                                end else begin
                                    sda_low_r <= addr_r && !master_r &&
                                                 dir_r && ack_rx_r &&
                                                 !shreg_r[7];
                                end
                            end
                        end
                    end
                end
                ST_IGNORE: begin
                    cnt_r <= '0;
                end
                ST_STOP: begin
                    if (hi_done) begin
                        state_r <= ST_IDLE;
                        sda_low_r <= 1'b0;
                        master_r <= 1'b0;
                        stop_flag_r <= stop_req_i; // New request wins
                    end
                end
            endcase
            // Foreign START: join as slave receiver
            if (start_det) begin
                busy_r <= 1'b1;
                if (!master_r) begin
                    state_r <= ST_XFER;
                    cnt_r <= '0;
                    tx_mode_r <= 1'b0;
                    addr_r <= 1'b1;
                    sda_low_r <= 1'b0;
                    inh_r <= slave_event_inhibit_i;
                end
            end
            // STOP seen on the bus
            if (stop_det) begin
                busy_r <= 1'b0;
                if (state_r == ST_XFER || state_r == ST_IGNORE) begin
                    state_r <= ST_IDLE;
                    master_r <= 1'b0;
                    sda_low_r <= 1'b0;
                end
                if (!master_r && !inh_r && state_r == ST_XFER) begin
                    irq_r <= 1'b1;
                    stop_flag_r <= 1'b1;
                end
            end
            if (free_done && !master_r) begin
                busy_r <= 1'b0;
                state_r <= ST_IDLE;
                sda_low_r <= 1'b0;
                irq_r <= 1'b1;
                stop_flag_r <= 1'b1;
            end
        end
    end

    // Outputs; pins only ever pulled low
    // open-drain drive
    assign scl_o = zero_r;
    assign sda_o = zero_r;
    assign scl_oe_o = scl_low_r;
    assign sda_oe_o = sda_low_r;
    assign irq_o = irq_r;
    assign master_o = master_r;
    assign tx_mode_o = tx_mode_r;
    assign start_flag_o = start_pend_r;
    assign stop_flag_o = stop_flag_r;
    assign ack_rx_o = ack_rx_r;
    assign arb_lost_o = arb_lost_r;
    assign busy_o = busy_r;
    assign data_o = shreg_r;
    assign timer_reload_o = reload_r;

    // Checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    AST_SCL_MASTER_ONLY: assert property (
        scl_oe_o |-> master_o || irq_o || $past(irq_o))
        else $error("SCL driven without master or hold");
    AST_RELOAD_HIGH: assert property (
        (enable_i && scl_low_timeout_enable_i && scl_f) [*2]
        |-> timer_reload_o)
        else $error("timer not reloading with SCL high");
    AST_START_IRQ: assert property (
        state_r == ST_START && hi_done && enable_i
        |=> irq_o && master_o && tx_mode_o && scl_oe_o ##0 sda_oe_o)
        else $error("START did not interrupt");
    AST_RX_IRQ: assert property (
        enable_i && state_r == ST_XFER && !irq_r && scl_fall &&
        cnt_r == ACK_CNT && !tx_mode_r && !(addr_r && !master_r && inh_r)
        |=> irq_o ##1 scl_oe_o)
        else $error("receive interrupt missing before ack");
    AST_TX_IRQ: assert property (
        enable_i && state_r == ST_XFER && !irq_r && scl_fall &&
        cnt_r == DONE_CNT && tx_mode_r && !free_done |=> irq_o)
        else $error("send interrupt missing after ack");
    AST_ARB_LOSS: assert property (
        enable_i && state_r == ST_XFER && !irq_r && scl_rise &&
        cnt_r < ACK_CNT && master_r && tx_mode_r && !sda_low_r && !sda_f
        |=> !master_o && arb_lost_o && !tx_mode_o)
        else $error("arbitration loss not taken");
    AST_INH_NACK: assert property (
        enable_i && state_r == ST_XFER && !irq_r && scl_fall &&
        cnt_r == ACK_CNT && !tx_mode_r && addr_r && !master_r && inh_r &&
        !stop_det && !free_done |=> !irq_o && !sda_oe_o)
        else $error("inhibited slave acked or interrupted");
    AST_FREE_STOP: assert property (
        free_done && !master_r |=> !busy_o && stop_flag_o && irq_o)
        else $error("free timeout not treated as STOP");
    AST_STRETCH_SYNC: assert property (
        enable_i && master_r && !irq_r && !scl_low_r && !scl_f &&
        state_r != ST_IDLE && state_r != ST_IGNORE |=> tcnt_r == '0)
        else $error("master advanced during stretch");
    AST_START_FREE: assert property (
        state_r == ST_IDLE ##1 state_r == ST_START |-> !$past(busy_r))
        else $error("START launched on busy bus");

    COV_MASTER_START: cover property (state_r == ST_START ##1
        state_r == ST_XFER);
    COV_ARB_LOST: cover property ($rose(arb_lost_r));
    COV_SLAVE_STOP: cover property (stop_det && !master_r &&
        state_r == ST_XFER);
    COV_FREE_TIMEOUT: cover property (free_done);

endmodule

//--- sim/twi_bus_slave.sv
// Bus slave model: acks its address, stretches SCL, keeps bytes
`timescale 1ns/1ps
module twi_bus_slave #(
    parameter logic [6:0] ADDR = 7'h52
) (
    // Bus lines
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_oe_o,
    output logic sda_oe_o,
    // Control and result
    input wire logic nack_i,
    output logic hit_o,
    output logic [7:0] byte_o
);
    logic [7:0] sh;
    logic act;
    logic first;
    int cnt;
    initial begin
        {act, first, sda_oe_o, scl_oe_o, hit_o} = 5'h0;
        {sh, byte_o} = 16'h0;
        cnt = 0;
    end
    always @(negedge sda_i) begin
        if (scl_i) begin
            {act, first, hit_o} = 3'h6;
            cnt = 0;
        end
    end
    always @(posedge sda_i) begin
        if (scl_i) act = 1'b0;
    end
    always @(posedge scl_i) begin
        if (act && cnt < 8) begin
            sh = {sh[6:0], sda_i};
            cnt++;
        end
    end
    always @(negedge scl_i) begin
        if (act && cnt == 8) begin
            if (first) hit_o = (sh[7:1] == ADDR) && !sh[0];
            else byte_o = sh;
            sda_oe_o = !nack_i && (sh[7:1] == ADDR || !first);
            cnt = 9;
            scl_oe_o = 1'b1;
            #100 scl_oe_o = 1'b0;
        end else if (act && cnt == 9) begin
            sda_oe_o = 1'b0;
            cnt = 0;
            first = 1'b0;
        end
    end
endmodule

//--- sim/twi_serial_port_bench.sv
// Testbench for the two-wire port against a bus slave model
`timescale 1ns/1ps
module twi_serial_port_bench;
    import twi_pkg::*;
    logic clk_i, resetn_i, tmo, sreq, preq, clr, wr, nack;
    logic irq, mst, txm, stf, spf, ackr, busy, rld, m_scl, m_sda;
    logic s_scl, s_sda, hit, arbl, en;
    logic [1:0] src;
    logic [3:0] tick;
    logic [7:0] din, dout, sbyte;
    int miscompares, num_checks, tc, s;
    wire scl = ~(m_scl | s_scl);
    wire sda = ~(m_sda | s_sda);

    twi_serial_port dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .enable_i(en), .slave_event_inhibit_i(1'b0),
        .scl_low_timeout_enable_i(tmo), .bus_free_timeout_enable_i(1'b0),
        .bit_clock_source_select_i(src), .tick_t0_i(tick[0]),
        .tick_t1_i(tick[1]), .tick_t2h_i(tick[2]), .tick_t2l_i(tick[3]),
        .start_req_i(sreq), .stop_req_i(preq), .irq_clear_i(clr),
        .ack_out_i(1'b1), .data_wr_i(wr), .data_i(din), .irq_o(irq),
        .master_o(mst), .tx_mode_o(txm), .start_flag_o(stf),
        .stop_flag_o(spf), .ack_rx_o(ackr), .arb_lost_o(arbl), .busy_o(busy),
        .data_o(dout), .timer_reload_o(rld), .scl_i(scl), .scl_o(),
        .scl_oe_o(m_scl), .sda_i(sda), .sda_o(), .sda_oe_o(m_sda));
    twi_bus_slave slv (.scl_i(scl), .sda_i(sda), .scl_oe_o(s_scl),
        .sda_oe_o(s_sda), .nack_i(nack), .hit_o(hit), .byte_o(sbyte));

    // Clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // Overflow ticks on the selected source only, every 48 ns
    always @(negedge clk_i) begin
        tc <= (tc == 11) ? 0 : tc + 1;
        tick <= 4'h0;
        if (tc == 0) tick[src] <= 1'b1;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Bounded wait for irq high (w=1) or bus idle (w=0)
    task automatic wait_for(input logic w);
        int i;
        for (i = 0; i < 3000; i++) begin
            if (w ? irq === 1'b1 : busy === 1'b0) break;
            @(negedge clk_i);
        end
        if (i == 3000) begin
            miscompares++;
            final_report();
        end
    endtask

    task automatic send(input logic [7:0] b);
        @(negedge clk_i);
        {din, wr, clr} = {b, 2'h3};
        @(negedge clk_i);
        {wr, clr} = 2'h0;
    endtask

    initial begin
        {resetn_i, sreq, preq, clr, wr, nack, src, tick, din} = 0;
        {tc, miscompares, num_checks} = 0;
        tmo = 1'b1;
        en = 1'b1;
        repeat (4) @(negedge clk_i);
        resetn_i = 1'b1;
        check({irq, mst, busy, m_scl, m_sda}, 8'h00);
        repeat (6) @(negedge clk_i);
        check({7'h0, rld}, 8'h01);
        for (s = 0; s < 4; s++) begin
            {src, nack} = {s[1:0], s[0]};
            @(negedge clk_i);
            sreq = 1'b1;
            @(negedge clk_i);
            sreq = 1'b0;
            wait_for(1'b1);
            check({4'h0, stf, mst, txm, busy}, 8'h07);
            send({7'h52, 1'b0});
            wait_for(1'b1);
            check({7'h0, ackr}, {7'h0, ~s[0]});
            check({7'h0, hit}, 8'h01);
            check(dout, {7'h52, 1'b0});
            if (s[0] == 1'b0) begin
                send(8'ha5 ^ s[7:0]);
                wait_for(1'b1);
                check(sbyte, 8'ha5 ^ s[7:0]);
            end
            @(negedge clk_i);
            preq = 1'b1;
            @(negedge clk_i);
            {preq, clr} = 2'h1;
            @(negedge clk_i);
            clr = 1'b0;
            wait_for(1'b0);
            check({4'h0, arbl, mst, spf, irq}, 8'h00);
            check({6'h0, scl, sda}, 8'h03);
        end
        en = 1'b0;
        @(negedge clk_i);
        en = 1'b1;
        check({5'h0, mst, busy, m_sda}, 8'h00);
        tmo = 1'b0;
        repeat (3) @(negedge clk_i);
        check({7'h0, rld}, 8'h00);
        final_report();
    end
endmodule
